// [hw/adcc_pkg.sv]
// adcc_pkg: constants for the chained converter serial port
// assumes a 25 MHz core clock that samples every pin
package adcc_pkg;
	localparam int unsigned RES_BITS     = 16;
	localparam int unsigned CLK_HZ       = 25000000;
	// conversion time in ns, as a plain default for the model
	localparam int unsigned CONV_TIME_NS = 400;
	localparam int unsigned CONV_CYC_RAW =
		(CONV_TIME_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int unsigned CONV_CYCLES  = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
	localparam logic [4:0]  CNT_W_MAX    = 5'h1f;
	typedef enum logic [1:0] {
		ADCC_IDLE,
		ADCC_CONV,
		ADCC_READ
	} adcc_state_t;
endpackage

// [hw/adcc_top.sv]
// adcc_top: device side of a daisy-chained 16-bit converter serial port
// assumes pins arrive asynchronously; sampled by ref_clk_i through two flops
// Operation
// - both chain input and conversion start low drive the data output low
// - start rising with clock low converts, chain mode, indicator off
// - start rising with clock high converts, chain mode, indicator on
// - no indicator: at conversion end put msb out, then acquire
// - later result bits shift out on successive clock falling edges
// - chain input enters shift register on each clock falling edge except the extra first one in indicator mode
// - indicator on: drive output high when conversion completes
// - each output bit after the first changes on a clock falling edge and stays stable across the rising edge; the first appears at conversion end
// - indicator mode only offered while high-rate select is low
`timescale 1ns/1ns
`default_nettype none
module adcc_top (
	// clock and reset
	input  wire logic                          ref_clk_i,
	input  wire logic                          rst_n_i,
	// link pins, all asynchronous to ref_clk_i
	input  wire logic                          conversion_start_input_i,
	input  wire logic                          sclk_i,
	input  wire logic                          serial_chain_input_i,
	input  wire logic                          high_rate_sel_i,
	// conversion result, from the analog core on ref_clk_i
	input  wire logic [adcc_pkg::RES_BITS-1:0] result_i,
	// serial output pin
	output logic                               serial_data_output_o,
	output logic                               serial_data_oe_n_o,
	output logic                               busy_ind_en_o
);
	import adcc_pkg::*;

	logic [3:0] s1_ff, s2_ff, nxt_s1, nxt_s2;
	logic       cnv_d_ff, sck_d_ff, nxt_cnv_d, nxt_sck_d;
	always_comb begin
		nxt_s1 = {high_rate_sel_i, serial_chain_input_i, sclk_i,
			conversion_start_input_i};
		nxt_s2 = s1_ff;
		nxt_cnv_d = s2_ff[0];
		nxt_sck_d = s2_ff[1];
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			s1_ff <= 4'h0;
			s2_ff <= 4'h0;
			cnv_d_ff <= 1'b0;
			sck_d_ff <= 1'b0;
		end else begin
			s1_ff <= nxt_s1;
			s2_ff <= nxt_s2;
			cnv_d_ff <= nxt_cnv_d;
			sck_d_ff <= nxt_sck_d;
		end
	end

	logic cnv_s, sck_s, sdi_s, turbo_s, cnv_rise, sck_fall;
	assign cnv_s = s2_ff[0];
	assign sck_s = s2_ff[1];
	assign sdi_s = s2_ff[2];
	assign turbo_s = s2_ff[3];
	assign cnv_rise = cnv_s && !cnv_d_ff;
	assign sck_fall = !sck_s && sck_d_ff;

	adcc_state_t        st_ff, nxt_st;
	logic [RES_BITS-1:0] sh_ff, nxt_sh;
	logic [8:0]          cnt_ff, nxt_cnt;
	logic                busy_ff, nxt_busy;
	logic                sdo_ff, nxt_sdo;
	logic                oe_n_ff, nxt_oe_n;

	always_comb begin
		nxt_st = st_ff;
		nxt_sh = sh_ff;
		nxt_cnt = cnt_ff;
		nxt_busy = busy_ff;
		nxt_sdo = sdo_ff;
		nxt_oe_n = oe_n_ff;
		if (cnv_rise) begin
			// clock level at the start edge picks the indicator mode
			nxt_st = ADCC_CONV;
			nxt_busy = sck_s && !turbo_s;
			nxt_cnt = 9'(CONV_CYCLES);
			nxt_sdo = 1'b0;
			nxt_oe_n = 1'b0;
		end else begin
			unique case (st_ff)
				ADCC_IDLE: begin
					if (!cnv_s && !sdi_s) begin
						nxt_sdo = 1'b0;
						nxt_oe_n = 1'b0;
					end else begin
						nxt_oe_n = 1'b1;
					end
				end
				ADCC_CONV: begin
					nxt_cnt = cnt_ff - 9'h1;
					if (cnt_ff == 9'h1) begin
						nxt_st = ADCC_READ;
						nxt_sh = result_i;
						if (busy_ff) begin
							// indicator high tells the host to start reading
							nxt_sdo = 1'h1;
						end else begin
							nxt_sdo = result_i[RES_BITS-1];
						end
					end
				end
				ADCC_READ: begin
					if (!cnv_s) begin
						// start dropped: readback is cut short
						nxt_st = ADCC_IDLE;
						nxt_oe_n = sdi_s;
						if (!sdi_s) begin
							nxt_sdo = 1'h0;
						end
					end else if (sck_fall && busy_ff) begin
						// the extra first fall presents the msb, no shift
						nxt_sdo = sh_ff[RES_BITS-1];
						nxt_busy = 1'h0;
					end else if (sck_fall) begin
						nxt_sh = {sh_ff[RES_BITS-2:0], sdi_s};
						nxt_sdo = sh_ff[RES_BITS-2];
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			st_ff <= ADCC_IDLE;
			sh_ff <= '0;
			cnt_ff <= 9'h0;
			busy_ff <= 1'b0;
			sdo_ff <= 1'b0;
			oe_n_ff <= 1'b1;
		end else begin
			st_ff <= nxt_st;
			sh_ff <= nxt_sh;
			cnt_ff <= nxt_cnt;
			busy_ff <= nxt_busy;
			sdo_ff <= nxt_sdo;
			oe_n_ff <= nxt_oe_n;
		end
	end

	logic busy_en_ff;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i)
			busy_en_ff <= 1'b0;
		else
			busy_en_ff <= nxt_busy;
	end

	assign serial_data_output_o = sdo_ff;
	assign serial_data_oe_n_o = oe_n_ff;
	assign busy_ind_en_o = busy_en_ff;

	// step sequences of a chain transfer; properties are built from them
	sequence s_start_low;
		cnv_rise && !sck_s;
	endsequence
	sequence s_start_high;
		cnv_rise && sck_s && !turbo_s;
	endsequence
	sequence s_conv_last;
		st_ff == ADCC_CONV && cnt_ff == 9'h1 && !cnv_rise;
	endsequence
	sequence s_read_fall;
		st_ff == ADCC_READ && cnv_s && sck_fall && !cnv_rise;
	endsequence
	sequence s_read_hold;
		st_ff == ADCC_READ && cnv_s && !sck_fall && !cnv_rise;
	endsequence

	property p_idle_low;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		st_ff == ADCC_IDLE && !cnv_s && !sdi_s && !cnv_rise
		|=> !sdo_ff && !oe_n_ff;
	endproperty
	property p_mode_low;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_start_low |=> st_ff == ADCC_CONV && !busy_ff;
	endproperty
	property p_mode_high;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_start_high |=> st_ff == ADCC_CONV && busy_ff;
	endproperty
	property p_turbo_off;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		cnv_rise && turbo_s |=> !busy_ff;
	endproperty
	property p_drive_conv;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		cnv_rise |=> !oe_n_ff;
	endproperty
	property p_msb_out;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_conv_last ##0 !busy_ff
		|=> st_ff == ADCC_READ && sdo_ff == $past(result_i[RES_BITS-1]);
	endproperty
	property p_busy_high;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_conv_last ##0 busy_ff |=> st_ff == ADCC_READ && sdo_ff;
	endproperty
	property p_first_fall;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_read_fall ##0 busy_ff
		|=> !busy_ff && $stable(sh_ff) && sdo_ff == sh_ff[RES_BITS-1];
	endproperty
	property p_shift_in;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_read_fall ##0 !busy_ff
		|=> sh_ff == {$past(sh_ff[RES_BITS-2:0]), $past(sdi_s)}
		&& sdo_ff == sh_ff[RES_BITS-1];
	endproperty
	property p_stable;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_read_hold |=> $stable(sdo_ff) && $stable(sh_ff);
	endproperty

	a_idle_low: assert property (p_idle_low)
		else $error("output not low in idle");
	a_mode_low: assert property (p_mode_low)
		else $error("indicator mode wrong on low clock");
	a_mode_high: assert property (p_mode_high)
		else $error("indicator mode wrong on high clock");
	a_turbo_off: assert property (p_turbo_off)
		else $error("indicator in turbo");
	a_drive_conv: assert property (p_drive_conv)
		else $error("output not driven after start");
	a_msb_out: assert property (p_msb_out)
		else $error("msb not presented");
	a_busy_high: assert property (p_busy_high)
		else $error("indicator not high");
	a_first_fall: assert property (p_first_fall)
		else $error("extra first fall wrong");
	a_shift_in: assert property (p_shift_in)
		else $error("shift wrong");
	a_stable: assert property (p_stable)
		else $error("output moved off falling edge");
endmodule // adcc_top
`default_nettype wire

// [tb/adcc_host.sv]
// adcc_host: host model driving start, serial clock and chain input
// assumes calls are made on the falling ref clock edge
`timescale 1ns/1ns
`default_nettype none
module adcc_host (
	// pins
	input  wire logic ref_clk_i,
	input  wire logic dout_i,
	output logic      start_o,
	output logic      sclk_o,
	output logic      chain_o
);
	initial begin
		start_o = 1'b0;
		sclk_o = 1'b0;
		chain_o = 1'b0;
	end
	task automatic go(input logic im);
		sclk_o = im;
		repeat (4) @(negedge ref_clk_i);
		start_o = 1'b1;
		repeat (20) @(negedge ref_clk_i);
	endtask
	// a: seen before each rise, b: before each fall
	task automatic read(input int n, input logic [31:0] up,
		output logic [32:0] a, output logic [32:0] b);
		a = '0;
		b = '0;
		for (int i = n - 1; i >= 0; i--) begin
			a[i] = dout_i;
			chain_o = up[i[4:0]];
			sclk_o = 1'b1;
			repeat (4) @(negedge ref_clk_i);
			b[i] = dout_i;
			sclk_o = 1'b0;
			repeat (4) @(negedge ref_clk_i);
		end
	endtask
	task automatic stop();
		start_o = 1'b0;
		chain_o = 1'b0;
		sclk_o = 1'b0;
		repeat (8) @(negedge ref_clk_i);
	endtask
endmodule // adcc_host
`default_nettype wire

// [tb/adcc_top_tb.sv]
// adcc_top_tb: chain readout of one device fed by an upstream word
// assumes the host model in adcc_host
`timescale 1ns/1ns
`default_nettype none
module adcc_top_tb;
	import adcc_pkg::*;
	logic                ref_clk_i;
	logic                rst_n_i;
	logic                hr;
	logic                dout;
	logic                oe_n;
	logic                ind;
	logic                start;
	logic                sclk;
	logic                chain;
	logic [RES_BITS-1:0] res;
	int                  n_fail = 0;
	int                  n_compared = 0;
	adcc_top dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.conversion_start_input_i(start), .sclk_i(sclk),
		.serial_chain_input_i(chain), .high_rate_sel_i(hr),
		.result_i(res), .serial_data_output_o(dout),
		.serial_data_oe_n_o(oe_n), .busy_ind_en_o(ind));
	adcc_host host (.ref_clk_i(ref_clk_i), .dout_i(dout),
		.start_o(start), .sclk_o(sclk), .chain_o(chain));
	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	task automatic check(input string s, input logic [32:0] g, e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s exp %h seen %h", s, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic t_idle();
		repeat (5) @(negedge ref_clk_i);
		check("idle", {dout, oe_n}, 2'h0);
	endtask
	// two-device chain: own result, then the upstream word
	task automatic t_chain(input logic im, input logic [15:0] u);
		logic [32:0] a;
		logic [32:0] b;
		host.go(im);
		check("mode", ind, im);
		check("drive", oe_n, 1'h0);
		host.read(32 + im, {u, 16'h0}, a, b);
		check("fall", b, {im, res, u});
		check("rise", a, {im, res, u});
		host.stop();
	endtask
	// high-rate select forbids the indicator
	task automatic t_fast();
		hr = 1'b1;
		host.go(1'b1);
		check("fast", ind, 1'b0);
		host.stop();
		hr = 1'b0;
	endtask
	initial begin
		rst_n_i = 1'b0;
		hr = 1'b0;
		res = 16'hb38d;
		repeat (16) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		t_idle();
		t_chain(1'b0, 16'h5a3c);
		res = 16'h8001;
		t_chain(1'b1, 16'hc3a5);
		t_fast();
		wrap_up();
	end
	initial begin
		#400000;
		n_fail++;
		wrap_up();
	end
endmodule // adcc_top_tb
`default_nettype wire
